// ===== verilog/amc_pkg.sv
// Package: offsets, field positions, reset values and timing for amc block
package amc_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 16;
  // Register offsets
  localparam logic [7:0] STATUS_OFS = 8'h01;
  localparam logic [7:0] MODE_OFS   = 8'h02;
  localparam logic [7:0] CLOCK_OFS  = 8'h03;
  localparam logic [7:0] GAIN_OFS   = 8'h04;
  localparam logic [7:0] IRQ_ST_OFS = 8'h10;
  localparam logic [7:0] IRQ_MK_OFS = 8'h11;
  // Reset values
  localparam logic [15:0] MODE_RST  = 16'h0510;
  localparam logic [15:0] CLOCK_RST = 16'h030E;
  localparam logic [15:0] GAIN_RST  = 16'h0000;
  localparam logic [3:0]  IRQ_RST   = 4'h0;
  // Operating-mode field positions
  localparam int unsigned REG_CRC_BIT  = 13;
  localparam int unsigned RX_CRC_BIT   = 12;
  localparam int unsigned CRC_POLY_BIT = 11;
  localparam int unsigned RST_FLAG_BIT = 10;
  localparam int unsigned WSIZE_LO     = 8;
  localparam int unsigned TIMEOUT_BIT  = 4;
  localparam int unsigned RSRC_LO      = 2;
  localparam int unsigned FLOAT_BIT    = 1;
  localparam int unsigned PULSE_BIT    = 0;
  // Conversion-clock field positions
  localparam int unsigned CHAN_ONE_ENABLE_BIT = 9;
  localparam int unsigned CHAN_ZERO_ENABLE_BIT = 8;
  localparam int unsigned TURBO_BIT  = 5;
  localparam int unsigned OSR_LO     = 2;
  localparam int unsigned PWR_LO     = 0;
  localparam logic [15:0] CLOCK_WMASK = 16'h03FF;
  // Status word positions
  localparam int unsigned STAT_CRC_BIT = 12;
  localparam int unsigned STAT_CH1_BIT = 1;
  localparam int unsigned STAT_CH0_BIT = 0;
  // Interrupt status bits
  localparam int unsigned IRQ_CH0 = 0;
  localparam int unsigned IRQ_CH1 = 1;
  localparam int unsigned IRQ_CRC = 2;
  localparam int unsigned IRQ_RDY = 3;
  // Ready-source encodings
  localparam logic [1:0] SRC_LAG = 2'h0;
  localparam logic [1:0] SRC_OR  = 2'h1;
  // Turbo ratio
  localparam logic [15:0] TURBO_OSR = 16'h0040;
  // Timing
  localparam int unsigned CLK_NS        = 100;
  localparam int unsigned PULSE_TIME_NS = 400;
  localparam int unsigned PULSE_CYCLES  =
    (PULSE_TIME_NS + CLK_NS - 1) / CLK_NS;
  // Pin driver states; one bit changes on every step from idle
  typedef enum logic [1:0] {
    AMC_IDLE  = 2'b00,
    AMC_PULSE = 2'b10,
    AMC_HOLD  = 2'b01
  } amc_pin_e;
endpackage

// ===== verilog/amc_regs.sv
// Operating-mode and conversion-clock register bank with ready pin driver
// Overview of operation
// RULE1: Bit 13 of mode enables register-map CRC, reset zero.
// RULE2: Bit 12 of mode enables serial-input CRC check, reset zero.
// RULE3: Bit 11 picks CRC polynomial: 0 CCITT, 1 ANSI, all uses.
// RULE4: Bit 10 reads 1 after reset; writing 0 clears reset flag.
// RULE5: Bits 9:8 set word size: 16, 24, 32 padded, 32 extended.
// RULE6: Bit 4 enables serial timeout, reset one.
// RULE7: Bits 3:2 pick ready source: lagging, OR, or leading channel.
// RULE8: Bit 1 idles ready pin high when 0, floating when 1.
// RULE9: Bit 0 signals data as low level or fixed low pulse.
// RULE10: Clock bits 9 and 8 enable channels 1 and 0, reset one.
// RULE11: Turbo bit 5 forces ratio 64, overriding the ratio field.
// RULE12: Bits 4:2 select ratio 128 up to 16256, default 1024.
// RULE13: Bits 1:0 select power mode, default high resolution.
// RULE14: Clock bits 15:10 are read-only zero.
// RULE15: Status bits 1 and 0 flag new data on channels 1 and 0.
// RULE16: Host writes zeros to reserved writable bits.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module amc_regs
  import amc_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)(
  input  wire  logic          ref_clk,
  input  wire  logic          rstn,
  input  wire  logic [AW-1:0] reg_addr,
  input  wire  logic [DW-1:0] reg_wdata,
  input  wire  logic          reg_wr,
  input  wire  logic          reg_rd,
  output logic [DW-1:0]       reg_rdata,
  input  wire  logic          chan_zero_sample,
  input  wire  logic          chan_one_sample,
  input  wire  logic          sample_read_done,
  input  wire  logic          rx_crc_error,
  output logic                reg_crc_enable,
  output logic                rx_crc_enable,
  output logic                crc_poly_ansi,
  output logic [1:0]          word_size_select,
  output logic                timeout_enable,
  output logic                chan_one_enable,
  output logic                chan_zero_enable,
  output logic [15:0]         effective_osr,
  output logic [1:0]          power_level_select,
  output logic [15:0]         channel_gain_select,
  output logic                conversion_ready_pin,
  output logic                conversion_ready_oe_n,
  output logic                irq
);

  logic [15:0] operating_mode_config;
  logic [15:0] conversion_clock_config;
  logic        reset_occurred;
  logic        crc_fault;
  logic        chan_zero_new_data;
  logic        chan_one_new_data;
  logic        lead_latch;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [3:0]  irq_event;
  logic        ready_cond;
  logic        ready_cond_q;
  logic        ready_rise;
  logic [1:0]  ready_source_select;
  logic        ready_idle_float;
  logic        ready_pulse_format;
  logic        turbo_ratio_select;
  logic [2:0]  oversample_ratio_select;
  logic [15:0] status_word;
  logic [15:0] mode_word;
  logic [15:0] clock_word;
  logic        wr_mode;
  logic        wr_clock;
  logic        wr_gain;
  logic        rd_status;
  logic        wr_irq_st;
  logic        wr_irq_mk;
  logic        ch0_evt;
  logic        ch1_evt;
  logic        crc_evt;
  amc_pin_e    pin_state;
  amc_pin_e    next_pin_state;
  logic [7:0]  pulse_cnt;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [7:0]    ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [15:0] osr_decode(input logic       turbo,
                                             input logic [2:0] code);
    logic [15:0] r;
    r = 16'h0400;
    if (turbo) begin
      r = TURBO_OSR;
    end else begin
      case (code)
        3'h0:    r = 16'h0080;
        3'h1:    r = 16'h0100;
        3'h2:    r = 16'h0200;
        3'h3:    r = 16'h0400;
        3'h4:    r = 16'h0800;
        3'h5:    r = 16'h1000;
        3'h6:    r = 16'h2000;
        default: r = 16'h3F80;
      endcase
    end
    osr_decode = r;
  endfunction

  assign wr_mode   = reg_wr && hit(reg_addr, MODE_OFS);
  assign wr_clock  = reg_wr && hit(reg_addr, CLOCK_OFS);
  assign wr_gain   = reg_wr && hit(reg_addr, GAIN_OFS);
  assign rd_status = reg_rd && hit(reg_addr, STATUS_OFS);
  assign wr_irq_st = reg_wr && hit(reg_addr, IRQ_ST_OFS);
  assign wr_irq_mk = reg_wr && hit(reg_addr, IRQ_MK_OFS);

  // Field views of the stored words
  assign reg_crc_enable     = operating_mode_config[REG_CRC_BIT]; // RULE1
  assign rx_crc_enable      = operating_mode_config[RX_CRC_BIT]; // RULE2
  assign crc_poly_ansi      = operating_mode_config[CRC_POLY_BIT]; // RULE3
  assign word_size_select   =
    operating_mode_config[WSIZE_LO +: 2]; // RULE5
  assign timeout_enable     = operating_mode_config[TIMEOUT_BIT]; // RULE6
  assign ready_source_select =
    operating_mode_config[RSRC_LO +: 2]; // RULE7
  assign ready_idle_float   = operating_mode_config[FLOAT_BIT]; // RULE8
  assign ready_pulse_format = operating_mode_config[PULSE_BIT]; // RULE9
  assign chan_one_enable    = conversion_clock_config[CHAN_ONE_ENABLE_BIT]; // RULE10
  assign chan_zero_enable   = conversion_clock_config[CHAN_ZERO_ENABLE_BIT]; // RULE10
  assign turbo_ratio_select = conversion_clock_config[TURBO_BIT];
  assign oversample_ratio_select = conversion_clock_config[OSR_LO +: 3];
  assign effective_osr      =
    osr_decode(turbo_ratio_select, oversample_ratio_select); // RULE11 RULE12
  assign power_level_select = conversion_clock_config[PWR_LO +: 2]; // RULE13

  // Mode register; bit 10 is stored, but reads show the reset flag in its place
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      operating_mode_config <= MODE_RST;
    end else if (wr_mode) begin
      operating_mode_config <= reg_wdata;
    end
  end

  // Clock register; top six bits never stored
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conversion_clock_config <= CLOCK_RST;
    end else if (wr_clock) begin
      conversion_clock_config <= reg_wdata & CLOCK_WMASK; // RULE14
    end
  end

  // Gain word kept raw; its fields are decoded elsewhere
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      channel_gain_select <= GAIN_RST;
    end else if (wr_gain) begin
      channel_gain_select <= reg_wdata;
    end
  end

  // Writing one leaves the flag alone; only a zero clears it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reset_occurred <= 1'b1;
    end else if (wr_mode && !reg_wdata[RST_FLAG_BIT]) begin
      reset_occurred <= 1'b0; // RULE4
    end
  end

  // New-data flags; a sample in the cycle of a read-out is kept
  assign ch0_evt = chan_zero_sample && chan_zero_enable;
  assign ch1_evt = chan_one_sample && chan_one_enable;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chan_zero_new_data <= 1'b0;
    end else if (ch0_evt) begin
      chan_zero_new_data <= 1'b1; // RULE15
    end else if (sample_read_done || !chan_zero_enable) begin
      chan_zero_new_data <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      chan_one_new_data <= 1'b0;
    end else if (ch1_evt) begin
      chan_one_new_data <= 1'b1; // RULE15
    end else if (sample_read_done || !chan_one_enable) begin
      chan_one_new_data <= 1'b0;
    end
  end

  // Input CRC fault: only counted when checking is on; read clears
  assign crc_evt = rx_crc_error && rx_crc_enable; // RULE2

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      crc_fault <= 1'b0;
    end else if (crc_evt) begin
      crc_fault <= 1'b1;
    end else if (rd_status) begin
      crc_fault <= 1'b0;
    end
  end

  // Leading channel: first enabled arrival holds until read-out
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lead_latch <= 1'b0;
    end else if (ch0_evt || ch1_evt) begin
      lead_latch <= 1'b1;
    end else if (sample_read_done) begin
      lead_latch <= 1'b0;
    end
  end

  // Ready condition by source; with no channel enabled only a held leading latch gives ready
  always_comb begin
    ready_cond = 1'b0;
    case (ready_source_select)
      SRC_LAG: begin
        ready_cond = (chan_zero_enable || chan_one_enable) &&
                     (chan_zero_new_data || !chan_zero_enable) &&
                     (chan_one_new_data || !chan_one_enable); // RULE7
      end
      SRC_OR: begin
        ready_cond = chan_zero_new_data || chan_one_new_data; // RULE7
      end
      default: begin
        ready_cond = lead_latch; // RULE7
      end
    endcase
  end

  // Registered copy finds the rising edge of the condition
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ready_cond_q <= 1'b0;
    end else begin
      ready_cond_q <= ready_cond;
    end
  end

  assign ready_rise = ready_cond && !ready_cond_q;

  // Pin driver: level mode holds low, pulse mode times a fixed low
  always_comb begin
    next_pin_state = pin_state;
    case (pin_state)
      AMC_IDLE: begin
        if (ready_rise && ready_pulse_format) begin
          next_pin_state = AMC_PULSE; // RULE9
        end else if (ready_cond && !ready_pulse_format) begin
          next_pin_state = AMC_HOLD; // RULE9
        end
      end
      AMC_PULSE: begin
        if (pulse_cnt == 8'(PULSE_LEN - 1)) begin
          next_pin_state = AMC_IDLE;
        end
      end
      AMC_HOLD: begin
        if (!ready_cond || ready_pulse_format) begin
          next_pin_state = AMC_IDLE;
        end
      end
      default: begin
        next_pin_state = AMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_state <= AMC_IDLE;
    end else begin
      pin_state <= next_pin_state;
    end
  end

  // Eight-bit count limits PULSE_LEN to 256 cycles
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pulse_cnt <= 8'h00;
    end else if (pin_state == AMC_PULSE) begin
      pulse_cnt <= pulse_cnt + 8'h01;
    end else begin
      pulse_cnt <= 8'h00;
    end
  end

  // Registered pin; low while active, idle high or floated
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      conversion_ready_pin  <= 1'b1;
      conversion_ready_oe_n <= 1'b0;
    end else if (next_pin_state != AMC_IDLE) begin
      conversion_ready_pin  <= 1'b0; // RULE9
      conversion_ready_oe_n <= 1'b0;
    end else begin
      conversion_ready_pin  <= 1'b1; // RULE8
      conversion_ready_oe_n <= ready_idle_float; // RULE8
    end
  end

  // Interrupts: sticky status, set wins over write-one clear
  assign irq_event[IRQ_CH0] = ch0_evt;
  assign irq_event[IRQ_CH1] = ch1_evt;
  assign irq_event[IRQ_CRC] = crc_evt;
  assign irq_event[IRQ_RDY] = ready_rise;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_status <= IRQ_RST;
    end else if (wr_irq_st) begin
      irq_status <= (irq_status & ~reg_wdata[3:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // Mask gates only the output; status still records every event
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      irq_mask <= IRQ_RST;
    end else if (wr_irq_mk) begin
      irq_mask <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read views
  always_comb begin
    mode_word = operating_mode_config;
    mode_word[RST_FLAG_BIT] = reset_occurred; // RULE4
    clock_word = conversion_clock_config & CLOCK_WMASK; // RULE14
    status_word = 16'h0000;
    status_word[STAT_CRC_BIT] = crc_fault;
    status_word[CRC_POLY_BIT] = crc_poly_ansi;
    status_word[RST_FLAG_BIT] = reset_occurred; // RULE4
    status_word[WSIZE_LO +: 2] = word_size_select;
    status_word[STAT_CH1_BIT] = chan_one_new_data; // RULE15
    status_word[STAT_CH0_BIT] = chan_zero_new_data; // RULE15
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        STATUS_OFS: reg_rdata <= status_word;
        MODE_OFS:   reg_rdata <= mode_word;
        CLOCK_OFS:  reg_rdata <= clock_word;
        GAIN_OFS:   reg_rdata <= channel_gain_select;
        IRQ_ST_OFS: reg_rdata <= {12'h000, irq_status};
        IRQ_MK_OFS: reg_rdata <= {12'h000, irq_mask};
        default:    reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ===== tb/amc_regs_props.sv
// Checker for the mode and clock register bank
`timescale 1ns/1ps
`default_nettype none
module amc_regs_props
  import amc_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)(
  input wire logic          ref_clk,
  input wire logic          rstn,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic          reg_crc_enable,
  input wire logic          rx_crc_enable,
  input wire logic          crc_poly_ansi,
  input wire logic [1:0]    word_size_select,
  input wire logic          timeout_enable,
  input wire logic          chan_one_enable,
  input wire logic          chan_zero_enable,
  input wire logic [15:0]   effective_osr,
  input wire logic [1:0]    power_level_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [DW-1:0] wd;
  logic          clr;
  wire mw = reg_wr && reg_addr == MODE_OFS;
  wire cw = reg_wr && reg_addr == CLOCK_OFS;
  // Write data of the previous cycle
  always_ff @(posedge ref_clk) begin
    wd <= reg_wdata;
  end
  // Set once software has cleared the reset flag
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clr <= 1'b0;
    end else if (mw && !reg_wdata[10]) begin
      clr <= 1'b1;
    end
  end
  function automatic logic [15:0] osr_of(input logic [2:0] c);
    return (c == 3'h7) ? 16'h3F80 : 16'h0080 << c;
  endfunction
  reg_crc_a: assert property (mw |=> reg_crc_enable == wd[13])
    else $error("register crc enable wrong");
  rx_crc_a: assert property (mw |=> rx_crc_enable == wd[12])
    else $error("input crc enable wrong");
  crc_poly_a: assert property (mw |=> crc_poly_ansi == wd[11])
    else $error("crc polynomial wrong");
  word_size_a: assert property (mw |=> word_size_select == wd[9:8])
    else $error("word size wrong");
  timeout_a: assert property (mw |=> timeout_enable == wd[4])
    else $error("timeout enable wrong");
  chan_en_a: assert property (
    cw |=> {chan_one_enable, chan_zero_enable} == wd[9:8])
    else $error("channel enable wrong");
  turbo_a: assert property (
    cw && reg_wdata[5] |=> effective_osr == 16'h0040)
    else $error("turbo ratio wrong");
  osr_sel_a: assert property (
    cw && !reg_wdata[5] |=> effective_osr == osr_of(wd[4:2]))
    else $error("ratio decode wrong");
  clk_ro_a: assert property (
    reg_rd && reg_addr == CLOCK_OFS |=> reg_rdata[15:10] == 6'h00)
    else $error("clock upper bits not zero");
  pwr_sel_a: assert property (cw |=> power_level_select == wd[1:0])
    else $error("power mode wrong");
  rst_flag_a: assert property (
    reg_rd && (reg_addr == MODE_OFS || reg_addr == STATUS_OFS)
      |=> reg_rdata[10] == !clr)
    else $error("reset flag read wrong");
  cover property (mw && !reg_wdata[10]);
  cover property (cw && reg_wdata[5]);
  cover property (reg_rd && reg_addr == STATUS_OFS);
endmodule
bind amc_regs amc_regs_props #(.PULSE_LEN(PULSE_LEN)) u_props (.*);
`default_nettype wire

// ===== tb/amc_host.sv
// Host controller model driving the register port
`timescale 1ns/1ps
`default_nettype none
module amc_host
  import amc_pkg::*;
(
  input  wire logic          ref_clk,
  output logic [AW-1:0]      reg_addr,
  output logic [DW-1:0]      reg_wdata,
  output logic               reg_wr,
  output logic               reg_rd,
  input  wire logic [DW-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d & (a == MODE_OFS ? 16'h3F1F :
      a == CLOCK_OFS ? 16'hFF3F : 16'hFFFF);
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Released data never keeps its last value
    reg_wdata <= ~reg_wdata;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== tb/amc_regs_tb.sv
// Self-checking bench for the mode and clock register bank
`timescale 1ns/1ps
`default_nettype none
module amc_regs_tb
  import amc_pkg::*;
;
  localparam int unsigned PL = 2;
  logic          ref_clk, rstn, reg_wr, reg_rd, pin, oe_n, irq;
  logic          rcrc, xcrc, poly, tmo, c1, c0;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, osr, rv, m_mode, m_clk, gn, gv;
  logic [1:0]    ws, pwr;
  logic [3:0]    ev;
  int            bad_count, total_checks, flag, n;
  amc_host u_host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  amc_regs #(.PULSE_LEN(PL)) DUT (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_zero_sample(ev[0]),
    .chan_one_sample(ev[1]), .sample_read_done(ev[2]),
    .rx_crc_error(ev[3]), .reg_crc_enable(rcrc), .rx_crc_enable(xcrc),
    .crc_poly_ansi(poly), .word_size_select(ws), .timeout_enable(tmo),
    .chan_one_enable(c1), .chan_zero_enable(c0), .effective_osr(osr),
    .power_level_select(pwr), .channel_gain_select(gn),
    .conversion_ready_pin(pin), .conversion_ready_oe_n(oe_n), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic r(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d);
    u_host.wr(a, d);
    if (a == MODE_OFS) m_mode = d & 16'h3F1F;
    if (a == MODE_OFS && !d[10]) flag = 0;
    if (a == CLOCK_OFS) m_clk = d & 16'h033F;
  endtask
  task automatic pulse(input logic [3:0] v, input int wt);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= 4'h0;
    repeat (wt) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [15:0] st(input logic [15:0] x);
    return (m_mode & 16'h0B00) | 16'(flag << 10) | x;
  endfunction
  function automatic logic [15:0] m_osr();
    if (m_clk[5]) return 16'h0040;
    return m_clk[4:2] == 3'h7 ? 16'h3F80 : 16'h0080 << m_clk[4:2];
  endfunction
  task automatic outs;
    #1;
    chk({rcrc, xcrc, poly, tmo, ws}, {m_mode[13:11], m_mode[4], m_mode[9:8]});
    chk({c1, c0, pwr}, {m_clk[9:8], m_clk[1:0]});
    chk(osr, m_osr());
  endtask
  task automatic rst_chk;
    flag = 1;
    m_mode = 16'h0510;
    m_clk = 16'h030E;
    r(MODE_OFS, 16'h0510);
    r(CLOCK_OFS, 16'h030E);
    r(STATUS_OFS, 16'h0500);
    r(GAIN_OFS, 16'h0000);
    outs;
    chk({pin, oe_n, irq}, 16'h0004);
    chk(gn, 16'h0000);
  endtask
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    end_sim;
  end
  initial begin
    bad_count = 0;
    total_checks = 0;
    rstn = 1'b0;
    ev = 4'h0;
    n = $urandom(32'h56BD0755);
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rst_chk;
    r(8'h07, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      w(MODE_OFS, 16'($urandom) & 16'h3F1F);
      w(CLOCK_OFS, (16'($urandom) & 16'hFF03) | 16'(i << 2));
      outs;
      r(MODE_OFS, (m_mode & 16'hFBFF) | 16'(flag << 10));
      r(CLOCK_OFS, m_clk);
      r(STATUS_OFS, st(16'h0000));
    end
    gv = 16'($urandom);
    w(GAIN_OFS, gv);
    r(GAIN_OFS, gv);
    chk(gn, gv);
    $display("random fields done");
    w(CLOCK_OFS, 16'h030E);
    w(MODE_OFS, 16'h0014);
    w(IRQ_MK_OFS, 16'h000F);
    pulse(4'h1, 1);
    chk({pin, oe_n, irq}, 16'h0001);
    r(STATUS_OFS, st(16'h0001));
    r(IRQ_ST_OFS, 16'h0009);
    w(IRQ_MK_OFS, 16'h0000);
    #1;
    chk(irq, 16'h0000);
    w(IRQ_ST_OFS, 16'h000F);
    r(IRQ_ST_OFS, 16'h0000);
    pulse(4'h4, 1);
    chk(pin, 16'h0001);
    w(CLOCK_OFS, 16'h020E);
    pulse(4'h1, 1);
    r(STATUS_OFS, st(16'h0000));
    pulse(4'h8, 0);
    r(IRQ_ST_OFS, 16'h0000);
    w(MODE_OFS, 16'h1014);
    pulse(4'h8, 0);
    r(STATUS_OFS, st(16'h1000));
    r(IRQ_ST_OFS, 16'h0004);
    w(IRQ_ST_OFS, 16'h000F);
    $display("events and interrupt done");
    w(CLOCK_OFS, 16'h030E);
    w(MODE_OFS, 16'h0010);
    pulse(4'h1, 1);
    chk(pin, 16'h0001);
    pulse(4'h2, 1);
    chk(pin, 16'h0000);
    pulse(4'h4, 1);
    w(MODE_OFS, 16'h0018);
    pulse(4'h2, 1);
    chk(pin, 16'h0000);
    pulse(4'h4, 1);
    $display("ready sources done");
    w(MODE_OFS, 16'h0017);
    pulse(4'h0, 1);
    chk(oe_n, 16'h0001);
    pulse(4'h1, 0);
    n = 0;
    repeat (8) begin
      @(posedge ref_clk);
      #1;
      if (pin === 1'b0 && oe_n === 1'b0) n++;
    end
    chk(16'(n), 16'(PL));
    chk({pin, oe_n}, 16'h0003);
    $display("pulse format done");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rst_chk;
    $display("second reset done");
    end_sim;
  end
endmodule
`default_nettype wire
